// ---- rtl/dase_encoder.sv ----
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps

// Operation
// - flag is 0 for a reading instruction, 1 for a writing one.
// - cache maintenance and address translation faults always report the flag as 1; only cache maintenance is forced to 1, translation faults follow is_write.
// - atomic read-write: 0 if a plain read would fault, else 1.
// - optional: stage 2 aborts on stage 1 walks for atomics may report 0.
// - flag is unknown for external aborts on atomics and codes 0x35, 0x31.
// - warm reset need not give either field a defined value.
// - status code is six bits, in syndrome bits 5 down to 0.
// - address size faults encode 0x00 to 0x03 for levels 0 to 3.
// - translation faults encode 0x04 to 0x07 for levels 0 to 3.
// - access flag faults encode 0x09 to 0x0b for levels 1 to 3.
// - no access flag or permission fault is ever reported at level 0.
// - external abort not on a walk or table update encodes 0x10.
// - external abort on walk 0x14 to 0x17; level -1 0x13 with wide addresses.
// - synchronous tag check fault encodes 0x11.
// - without reliability feature parity error 0x18, on walks 0x1c to 0x1f.
// - without reliability, with wide addresses, level -1 walk parity error is 0x1b.
// - granule protection on walk 0x24 to 0x27, not on walk 0x28.
// - granule protection on level -1 walk with wide addresses is 0x23.
// - wide addresses: level -1 address size 0x29, translation 0x2b.
// - alignment 0x21, TLB conflict 0x30, unsupported atomic update 0x31.
// - lockdown fault 0x32, unsupported exclusive or atomic access 0x33.
// - no reserved status code value is ever produced.
// - with the walk flag set, level is that of the stage 2 lookup.
// - walk flag bit 7 is set for stage 2 faults on stage 1 walks.
module dase_encoder
  import dase_pkg::*;
#(
  parameter bit WIDE_PA = 1'b1,
  parameter bit RELIABILITY = 1'b0,
  parameter bit REALM_MGMT = 1'b1,
  parameter bit MEM_TAGGING = 1'b1,
  parameter bit RELAX_ALLOWED = 1'b1,
  parameter logic [5:0] PERM_L1 = 6'h0d,
  parameter logic [5:0] PERM_L2 = 6'h0e,
  parameter logic [5:0] PERM_L3 = 6'h0f
)
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // abort from the core
  input wire logic abort_valid,
  input wire dase_req_t abort_req,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // captured syndrome
  output dase_synd_t synd,
  output logic synd_taken,
  output logic illegal
);

  // ----------------------------------------------------------------
  // encoding
  // ----------------------------------------------------------------

  // level n code from a level 0 base
  function automatic logic [5:0] dase_lvl(input logic [5:0] base, input logic [1:0] lvl);
    dase_lvl = base + {4'h0, lvl};
  endfunction : dase_lvl

  // returns {legal, code}; illegal combinations never reach the syndrome
  function automatic logic [6:0] dase_encode(input dase_req_t r);
    logic lm1;
    logic l03;
    logic legal;
    logic [5:0] code;
    lm1 = (r.level == DASE_LEVEL_M1);
    l03 = ~r.level[2];
    legal = 1'b0;
    code = 6'h00;
    // level carries the stage 2 lookup level when walking
    unique case (r.kind)
      DASE_K_ADDR_SIZE:
      begin
        if (l03)
        begin
          legal = 1'b1;
          code = dase_lvl(DASE_ADDR_SIZE_L0, r.level[1:0]);
        end
        else if (lm1 && WIDE_PA)
        begin
          legal = 1'b1;
          code = DASE_ADDR_SIZE_LM1;
        end
      end
      DASE_K_TRANSLATION:
      begin
        if (l03)
        begin
          legal = 1'b1;
          code = dase_lvl(DASE_TRANSL_L0, r.level[1:0]);
        end
        else if (lm1 && WIDE_PA)
        begin
          legal = 1'b1;
          code = DASE_TRANSL_LM1;
        end
      end
      DASE_K_ACCESS_FLAG:
      begin
        // never at level 0
        if (l03 && r.level[1:0] != 2'h0)
        begin
          legal = 1'b1;
          code = dase_lvl(DASE_ACCESS_BASE, r.level[1:0]);
        end
      end
      DASE_K_PERMISSION:
      begin
        if (l03 && r.level[1:0] != 2'h0)
        begin
          legal = 1'b1;
          // open encodings held as parameters
          unique case (r.level[1:0])
            2'h1: code = PERM_L1;
            2'h2: code = PERM_L2;
            default: code = PERM_L3;
          endcase
        end
      end
      DASE_K_EXT_ABORT:
      begin
        if (!r.on_walk)
        begin
          legal = 1'b1;
          code = DASE_EXT_ABORT;
        end
        else if (l03)
        begin
          legal = 1'b1;
          code = dase_lvl(DASE_EXT_WALK_L0, r.level[1:0]);
        end
        else if (lm1 && WIDE_PA)
        begin
          legal = 1'b1;
          code = DASE_EXT_WALK_LM1;
        end
      end
      DASE_K_TAG_CHECK:
      begin
        legal = MEM_TAGGING;
        code = DASE_TAG_CHECK;
      end
      DASE_K_PARITY:
      begin
        if (!RELIABILITY)
        begin
          if (!r.on_walk)
          begin
            legal = 1'b1;
            code = DASE_PARITY;
          end
          else if (l03)
          begin
            legal = 1'b1;
            code = dase_lvl(DASE_PARITY_WALK_L0, r.level[1:0]);
          end
          else if (lm1 && WIDE_PA)
          begin
            legal = 1'b1;
            code = DASE_PARITY_WALK_LM1;
          end
        end
      end
      DASE_K_ALIGNMENT:
      begin
        legal = 1'b1;
        code = DASE_ALIGNMENT;
      end
      DASE_K_GPF:
      begin
        if (REALM_MGMT)
        begin
          if (!r.on_walk)
          begin
            legal = 1'b1;
            code = DASE_GPF;
          end
          else if (l03)
          begin
            legal = 1'b1;
            code = dase_lvl(DASE_GPF_WALK_L0, r.level[1:0]);
          end
          else if (lm1 && WIDE_PA)
          begin
            legal = 1'b1;
            code = DASE_GPF_WALK_LM1;
          end
        end
      end
      DASE_K_TLB_CONFLICT:
      begin
        legal = 1'b1;
        code = DASE_TLB_CONFLICT;
      end
      DASE_K_UNSUP_ATOMIC_HW:
      begin
        legal = 1'b1;
        code = DASE_UNSUP_ATOMIC_HW;
      end
      DASE_K_LOCKDOWN:
      begin
        legal = 1'b1;
        code = DASE_LOCKDOWN;
      end
      DASE_K_UNSUP_EXCL:
      begin
        legal = 1'b1;
        code = DASE_UNSUP_EXCL;
      end
      default:
      begin
        legal = 1'b0;
        code = 6'h00;
      end
    endcase
    dase_encode = {legal, code};
  endfunction : dase_encode

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  dase_synd_t synd_q;
  dase_synd_t synd_d;
  logic taken_q;
  logic taken_d;
  logic illegal_q;
  logic illegal_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [6:0] enc;
  logic wr_flag;
  logic relax;
  logic clr_valid;
  logic clr_illegal;

  // code and legality of the incoming abort
  assign enc = dase_encode(abort_req);
  assign relax = RELAX_ALLOWED & ctrl_q[DASE_CTRL_RELAX_BIT];

  // write-not-read flag selection
  always_comb
  begin
    if (abort_req.is_cache_maint)
      wr_flag = 1'b1;
    else if (abort_req.is_atomic)
    begin
      // external aborts on atomics take this path too; any value is allowed
      if (relax && abort_req.stage2 && abort_req.s1_walk)
        wr_flag = 1'b0;
      else
        wr_flag = ~abort_req.atomic_read_faults;
    end
    else
      wr_flag = abort_req.is_write;
  end

  // software clears by writing one to a status bit
  assign clr_valid = reg_wr && reg_addr == DASE_ADDR_SYND && reg_wdata[DASE_SYND_VALID_BIT];
  assign clr_illegal = reg_wr && reg_addr == DASE_ADDR_SYND && reg_wdata[DASE_SYND_ILLEGAL_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------

  // capture, status and register reads
  always_comb
  begin
    ctrl_d = ctrl_q;
    synd_d = synd_q;
    taken_d = 1'b0;
    illegal_d = illegal_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr && reg_addr == DASE_ADDR_CTRL)
      ctrl_d = reg_wdata[1:0];
    if (clr_valid)
      synd_d.valid = 1'b0;
    if (clr_illegal)
      illegal_d = 1'b0;
    // a capture in the same cycle as a clear wins
    if (abort_valid && ctrl_q[DASE_CTRL_CAPT_BIT])
    begin
      if (enc[6])
      begin
        // all fields move together
        synd_d.data_fault_status_code = enc[5:0];
        synd_d.write_not_read_flag = wr_flag;
        synd_d.stage1_walk_fault_flag = abort_req.stage2 & abort_req.s1_walk;
        synd_d.valid = 1'b1;
        taken_d = 1'b1;
      end
      else
        illegal_d = 1'b1;
    end
    if (reg_rd)
    begin
      if (reg_addr == DASE_ADDR_CTRL)
        rdata_d = {30'h0, ctrl_q};
      else if (reg_addr == DASE_ADDR_SYND)
        rdata_d = {22'h0, illegal_q, synd_q};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // defined reset values, though any would do
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= DASE_CTRL_RESET;
      synd_q <= '0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      synd_q <= synd_d;
      taken_q <= taken_d;
      illegal_q <= illegal_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign synd = synd_q;
  assign synd_taken = taken_q;
  assign illegal = illegal_q;
  assign reg_rdata = rdata_q;

endmodule : dase_encoder

// ---- include/dase_pkg.sv ----
package dase_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] DASE_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DASE_ADDR_SYND = 4'h4;
  localparam int DASE_CTRL_RELAX_BIT = 0;
  localparam int DASE_CTRL_CAPT_BIT = 1;
  localparam logic [1:0] DASE_CTRL_RESET = 2'h2;
  localparam int DASE_SYND_CODE_LSB = 0;
  localparam int DASE_SYND_WRITE_BIT = 6;
  localparam int DASE_SYND_WALK_BIT = 7;
  localparam int DASE_SYND_VALID_BIT = 8;
  localparam int DASE_SYND_ILLEGAL_BIT = 9;

  // ----------------------------------------------------------------
  // status code values
  // ----------------------------------------------------------------
  localparam logic [5:0] DASE_ADDR_SIZE_L0 = 6'h00;
  localparam logic [5:0] DASE_TRANSL_L0 = 6'h04;
  localparam logic [5:0] DASE_ACCESS_BASE = 6'h08;
  localparam logic [5:0] DASE_EXT_ABORT = 6'h10;
  localparam logic [5:0] DASE_TAG_CHECK = 6'h11;
  localparam logic [5:0] DASE_EXT_WALK_LM1 = 6'h13;
  localparam logic [5:0] DASE_EXT_WALK_L0 = 6'h14;
  localparam logic [5:0] DASE_PARITY = 6'h18;
  localparam logic [5:0] DASE_PARITY_WALK_LM1 = 6'h1b;
  localparam logic [5:0] DASE_PARITY_WALK_L0 = 6'h1c;
  localparam logic [5:0] DASE_ALIGNMENT = 6'h21;
  localparam logic [5:0] DASE_GPF_WALK_LM1 = 6'h23;
  localparam logic [5:0] DASE_GPF_WALK_L0 = 6'h24;
  localparam logic [5:0] DASE_GPF = 6'h28;
  localparam logic [5:0] DASE_ADDR_SIZE_LM1 = 6'h29;
  localparam logic [5:0] DASE_TRANSL_LM1 = 6'h2b;
  localparam logic [5:0] DASE_TLB_CONFLICT = 6'h30;
  localparam logic [5:0] DASE_UNSUP_ATOMIC_HW = 6'h31;
  localparam logic [5:0] DASE_LOCKDOWN = 6'h32;
  localparam logic [5:0] DASE_UNSUP_EXCL = 6'h33;

  // lookup level, two's complement: 3'h7 is level -1
  localparam logic [2:0] DASE_LEVEL_M1 = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DASE_K_ADDR_SIZE = 4'h0,
    DASE_K_TRANSLATION = 4'h1,
    DASE_K_ACCESS_FLAG = 4'h2,
    DASE_K_PERMISSION = 4'h3,
    DASE_K_EXT_ABORT = 4'h4,
    DASE_K_TAG_CHECK = 4'h5,
    DASE_K_PARITY = 4'h6,
    DASE_K_ALIGNMENT = 4'h7,
    DASE_K_GPF = 4'h8,
    DASE_K_TLB_CONFLICT = 4'h9,
    DASE_K_UNSUP_ATOMIC_HW = 4'ha,
    DASE_K_LOCKDOWN = 4'hb,
    DASE_K_UNSUP_EXCL = 4'hc
  } dase_kind_t;

  typedef struct packed {
    dase_kind_t kind;
    logic [2:0] level;
    logic on_walk;
    logic is_write;
    logic is_cache_maint;
    logic is_atomic;
    logic atomic_read_faults;
    logic stage2;
    logic s1_walk;
  } dase_req_t;

  typedef struct packed {
    logic valid;
    logic stage1_walk_fault_flag;
    logic write_not_read_flag;
    logic [5:0] data_fault_status_code;
  } dase_synd_t;

endpackage : dase_pkg

// ---- bench/dase_checker_sva.sv ----
`timescale 1ns/100ps
// --------------------------------
// syndrome checker
// --------------------------------
module dase_checker_sva
  import dase_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // abort and register port
  input wire logic abort_valid,
  input wire dase_req_t abort_req,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // syndrome
  input wire dase_synd_t synd,
  input wire logic synd_taken,
  input wire logic illegal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // captures of one abort class
  sequence s_plain;
    abort_valid && !abort_req.is_cache_maint && !abort_req.is_atomic
      && abort_req.kind != DASE_K_UNSUP_ATOMIC_HW ##1 synd_taken;
  endsequence
  sequence s_cm;
    abort_valid && abort_req.is_cache_maint && !abort_req.is_atomic ##1 synd_taken;
  endsequence
  sequence s_ext;
    abort_valid && abort_req.kind == DASE_K_EXT_ABORT && !abort_req.on_walk ##1 synd_taken;
  endsequence
  sequence s_tag;
    abort_valid && abort_req.kind == DASE_K_TAG_CHECK ##1 synd_taken;
  endsequence

  property p_taken_cause;
    synd_taken |-> $past(abort_valid) && synd.valid;
  endproperty
  property p_plain_write;
    s_plain |-> synd.write_not_read_flag == $past(abort_req.is_write);
  endproperty
  property p_cm_write;
    s_cm |-> synd.write_not_read_flag;
  endproperty
  property p_walk_flag;
    synd_taken |-> synd.stage1_walk_fault_flag == ($past(abort_req.stage2) && $past(abort_req.s1_walk));
  endproperty
  property p_lvl0_drop;
    abort_valid && abort_req.kind inside {DASE_K_ACCESS_FLAG, DASE_K_PERMISSION}
      && abort_req.level == 3'h0 |=> !synd_taken;
  endproperty
  property p_code_legal;
    synd_taken |-> synd.data_fault_status_code inside {[6'h00:6'h07], [6'h09:6'h0b], [6'h0d:6'h11],
      [6'h13:6'h18], [6'h1b:6'h1f], 6'h21, [6'h23:6'h29], 6'h2b, [6'h30:6'h33]};
  endproperty
  property p_ext_code;
    s_ext |-> synd.data_fault_status_code == DASE_EXT_ABORT;
  endproperty
  property p_tag_code;
    s_tag |-> synd.data_fault_status_code == DASE_TAG_CHECK;
  endproperty
  property p_rd_synd;
    reg_rd && reg_addr == DASE_ADDR_SYND && !abort_valid |=> reg_rdata[9:0] == {$past(illegal), $past(synd)};
  endproperty

  a_taken_cause: assert property (p_taken_cause)
    else $error("capture without abort");
  a_plain_write: assert property (p_plain_write)
    else $error("write flag wrong");
  a_cm_write: assert property (p_cm_write)
    else $error("maintenance write flag wrong");
  a_walk_flag: assert property (p_walk_flag)
    else $error("walk flag wrong");
  a_lvl0_drop: assert property (p_lvl0_drop)
    else $error("level 0 fault captured");
  a_code_legal: assert property (p_code_legal)
    else $error("reserved code");
  a_ext_code: assert property (p_ext_code)
    else $error("external abort code wrong");
  a_tag_code: assert property (p_tag_code)
    else $error("tag check code wrong");
  a_rd_synd: assert property (p_rd_synd)
    else $error("syndrome read wrong");
endmodule : dase_checker_sva

// ---- bench/dase_core_model.sv ----
`timescale 1ns/100ps
// core side: issues one-cycle aborts
module dase_core_model
  import dase_pkg::*;
(
  // clock
  input wire logic clk,
  // abort to the encoder
  output logic abort_valid,
  output dase_req_t abort_req
);
  // idle at time zero
  initial
  begin
    abort_valid = 1'b0;
    abort_req = '0;
  end

  // request inverted afterwards so stale fields are never trusted
  task automatic fire(input dase_req_t r);
    @(posedge clk);
    abort_valid <= 1'b1;
    abort_req <= r;
    @(posedge clk);
    abort_valid <= 1'b0;
    abort_req <= dase_req_t'(~r);
  endtask : fire
endmodule : dase_core_model

// ---- bench/data_abort_syndrome_encoder_tb.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module data_abort_syndrome_encoder_tb
  import dase_pkg::*;
;
  logic clk, sys_rst, abort_valid, reg_wr, reg_rd, synd_taken, illegal, m_ill;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [8:0] m_synd, m_msk;
  dase_req_t abort_req, r;
  dase_synd_t synd;
  bit relax;
  int n_fail, compares;
  int lv_tab[5] = '{0, 1, 2, 3, 7};

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dase_core_model core (.clk(clk), .abort_valid(abort_valid), .abort_req(abort_req));
  dase_encoder dut (.clk(clk), .sys_rst(sys_rst), .abort_valid(abort_valid), .abort_req(abort_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .synd(synd), .synd_taken(synd_taken), .illegal(illegal));

  // --------------------------------
  // reference model
  // --------------------------------
  function automatic int exp_code(dase_req_t q);
    int l;
    l = q.level;
    case (q.kind)
      DASE_K_ADDR_SIZE: return l < 4 ? l : l == 7 ? 'h29 : -1;
      DASE_K_TRANSLATION: return l < 4 ? 4 + l : l == 7 ? 'h2b : -1;
      DASE_K_ACCESS_FLAG: return (l > 0 && l < 4) ? 8 + l : -1;
      DASE_K_PERMISSION: return (l > 0 && l < 4) ? 'h0c + l : -1;
      DASE_K_EXT_ABORT: return !q.on_walk ? 'h10 : l < 4 ? 'h14 + l : l == 7 ? 'h13 : -1;
      DASE_K_TAG_CHECK: return 'h11;
      DASE_K_PARITY: return !q.on_walk ? 'h18 : l < 4 ? 'h1c + l : l == 7 ? 'h1b : -1;
      DASE_K_ALIGNMENT: return 'h21;
      DASE_K_GPF: return !q.on_walk ? 'h28 : l < 4 ? 'h24 + l : l == 7 ? 'h23 : -1;
      DASE_K_TLB_CONFLICT: return 'h30;
      DASE_K_UNSUP_ATOMIC_HW: return 'h31;
      DASE_K_LOCKDOWN: return 'h32;
      DASE_K_UNSUP_EXCL: return 'h33;
      default: return -1;
    endcase
  endfunction : exp_code

  function automatic bit exp_write(dase_req_t q);
    if (q.is_cache_maint)
      return 1'b1;
    if (q.is_atomic)
      return (relax && q.stage2 && q.s1_walk) ? 1'b0 : !q.atomic_read_faults;
    return q.is_write;
  endfunction : exp_write

  function automatic dase_req_t rnd(int k, int l, int w);
    dase_req_t q;
    q.kind = dase_kind_t'(k[3:0]);
    q.level = l[2:0];
    q.on_walk = w[0];
    {q.is_write, q.is_cache_maint, q.is_atomic, q.atomic_read_faults, q.stage2, q.s1_walk} = 6'($urandom);
    if (q.is_cache_maint)
      q.is_atomic = 1'b0;
    return q;
  endfunction : rnd

  // --------------------------------
  // drivers and checks
  // --------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd

  task automatic do_abort(input dase_req_t q);
    int c;
    c = exp_code(q);
    core.fire(q);
    #1;
    if (c < 0)
    begin
      `CHK(synd_taken, 1'b0)
      m_ill = 1'b1;
    end
    else
    begin
      `CHK(synd_taken, 1'b1)
      `CHK(synd.data_fault_status_code, 6'(c))
      m_synd = {1'b1, q.stage2 & q.s1_walk, exp_write(q), 6'(c)};
      m_msk = ((q.kind == DASE_K_EXT_ABORT && q.is_atomic) || c == 'h31) ? 9'h1bf : 9'h1ff;
    end
    `CHK(synd & m_msk, m_synd & m_msk)
    `CHK(illegal, m_ill)
  endtask : do_abort

  task automatic complete_run;
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // --------------------------------
  // main sequence
  // --------------------------------
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    m_synd = 9'h0;
    m_msk = 9'h1ff;
    m_ill = 1'b0;
    void'($urandom(32'h0f9dee0c));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(DASE_ADDR_CTRL);
    `CHK(rd_v, {30'h0, DASE_CTRL_RESET})
    rd(DASE_ADDR_SYND);
    `CHK(rd_v, 32'h0)
    wr(4'h8, 32'hffff_ffff);
    rd(4'h8);
    `CHK(rd_v, 32'h0)
    rd(DASE_ADDR_CTRL);
    `CHK(rd_v, {30'h0, DASE_CTRL_RESET})
    // every kind, levels 0 to 3 and -1, both walk settings, then random
    for (int k = 0; k < 16; k++)
      for (int li = 0; li < 5; li++)
        for (int w = 0; w < 2; w++)
          do_abort(rnd(k, lv_tab[li], w));
    repeat (200) do_abort(rnd($urandom_range(15, 0), lv_tab[$urandom_range(4, 0)], $urandom_range(1, 0)));
    do_abort(rnd(DASE_K_TRANSLATION, 5, 0));
    rd(DASE_ADDR_SYND);
    `CHK(rd_v[9:0] & {1'b1, m_msk}, {m_ill, m_synd} & {1'b1, m_msk})
    // clear valid and illegal
    wr(DASE_ADDR_SYND, 32'h300);
    m_ill = 1'b0;
    m_synd[8] = 1'b0;
    rd(DASE_ADDR_SYND);
    `CHK(rd_v[9:0] & {1'b1, m_msk}, {m_ill, m_synd} & {1'b1, m_msk})
    // capture and clear in one cycle: the capture wins
    m_ill = 1'b0;
    fork
      do_abort(rnd(DASE_K_ALIGNMENT, 0, 0));
      wr(DASE_ADDR_SYND, 32'h300);
    join
    m_synd[8] = 1'b0;
    fork
      do_abort(rnd(DASE_K_ACCESS_FLAG, 0, 0));
      wr(DASE_ADDR_SYND, 32'h300);
    join
    // relaxed atomic walk abort
    wr(DASE_ADDR_CTRL, 32'h3);
    relax = 1'b1;
    r = rnd(DASE_K_TRANSLATION, 1, 1);
    {r.is_cache_maint, r.is_atomic, r.atomic_read_faults, r.stage2, r.s1_walk} = 5'h0b;
    do_abort(r);
    // capture disabled: abort ignored
    wr(DASE_ADDR_CTRL, 32'h0);
    core.fire(rnd(DASE_K_ALIGNMENT, 0, 0));
    #1;
    `CHK(synd_taken, 1'b0)
    `CHK(synd & m_msk, m_synd & m_msk)
    wr(DASE_ADDR_CTRL, 32'h2);
    relax = 1'b0;
    // reset in mid run
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    `CHK(synd, 9'h0)
    `CHK(illegal, 1'b0)
    m_synd = 9'h0;
    m_ill = 1'b0;
    do_abort(rnd(DASE_K_PARITY, 7, 1));
    complete_run;
  end

  // watchdog
  initial
  begin
    #(25 * 4000);
    n_fail++;
    complete_run;
  end
endmodule : data_abort_syndrome_encoder_tb

bind dase_encoder dase_checker_sva u_chk (.clk(clk), .sys_rst(sys_rst), .abort_valid(abort_valid),
  .abort_req(abort_req), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synd(synd),
  .synd_taken(synd_taken), .illegal(illegal));
